// ==== core/lpc_ctrl.sv ====
// Low-power mode, clock lock and time base controller with AXI4-Lite registers.
// Assumes one 100 MHz clock, the crystal sampled as a synchronous input, and
// the bus interface reporting when its current cycle has ended.
// Operation
// (RULE_01) Block new cycles, finish current, then gate
// (RULE_02) Debug keeps oscillator and PLL running
// (RULE_03) Mode field resets and exits to normal
// (RULE_04) Single-chip stops system clock output only
// (RULE_05) Doze stops output and internal clocks
// (RULE_06) Light modes exit on reset, irqs, timers
// (RULE_07) Wake source holds exit two cycles
// (RULE_08) Sleep stops everything, detects exit asynchronously; code registers the exit on the rising clock edge
// (RULE_09) Sleep ignores decrementer and periodic timer
// (RULE_10) Clocks restart after fixed exit delay
// (RULE_11) Unmasked irq low clears mode always
// (RULE_12) Mask zero blocks irqs; mask always writable
// (RULE_13) Lock bits ignore writes to guarded fields
// (RULE_14) Locks stick until clock reset, except freeze
// (RULE_15) Wake bit drives pin, written directly
// (RULE_16) Decrementer MSB rise sets wake bit
// (RULE_17) Time base free-running, no reset
// (RULE_18) Decrementer interrupt on zero passing, maskable
// (RULE_19) Decrementer ignores reset, keeps counting
// (RULE_20) Counters tick at crystal over four
// (RULE_21) Freeze stop halts counters at falling edge
// (RULE_22) Decrementer enable applies at next tick
// (RULE_23) Clock reset from external, oscillator, lock loss
`include "lpc_consts.svh"
module lpc_ctrl
    import lpc_pkg::*;
#(
    parameter int SLEEP_WAKE_CYC = (`LPC_SLEEP_WAKE_NS + `LPC_CLK_NS - 1) / `LPC_CLK_NS
)(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        ext_reset_n,
    input  wire logic [1:0]  irq_n,
    input  wire logic        osc_lost,
    input  wire logic        pll_unlocked,
    input  wire logic        xtal_clk,
    input  wire logic        debug_mode,
    input  wire logic        freeze,
    input  wire logic        interrupt_enable_bit,
    input  wire logic        pit_irq,
    input  wire logic        bus_cycle_busy,
    output logic             bus_block_r,
    output lpc_gates_t       gates_r,
    output logic             power_up_request_pin,
    output logic             dec_irq_r,
    output logic             clock_reset_r
);
    localparam logic [7:0] SLEEP_CYC = 8'(SLEEP_WAKE_CYC);
    logic        irq_wake_mask_r, dec_en_r, lol_re_r, loo_re_r;
    logic [3:0]  pll_multiplier_r, output_divider_r;
    logic [1:0]  power_mode_select_r, held_mode_r;
    logic        mul_lock_r, mode_lock_r, div_lock_r;
    logic        wake_request_bit_r, frz_stop_r;
    logic [63:0] timebase_r;
    logic [31:0] dec_r;
    logic        dec_en_live_r;
    logic [1:0]  xdiv_r;
    logic        xtal_q_r, tick_r, frz_n_r;
    logic [7:0]  exit_cnt_r;
    logic        exit_async_r;
    lpc_state_t  state_r;
    logic        aw_hold_r, w_hold_r, ar_busy_r;
    logic [11:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        wr_fire, wr_ok, rd_fire;
    logic [31:0] ctrl_word, lock_word, rd_word;
    logic        irq_wake, exit_light, exit_sleep, exit_any, low_sel, clk_rst;
    // Wake sources; only the irq pins are gated by the mask, reset and timers are not.
    assign irq_wake   = irq_wake_mask_r & ~(&irq_n);                  // RULE_12
    assign exit_sleep = ~ext_reset_n | irq_wake;                      // RULE_09
    assign exit_light = exit_sleep | dec_irq_r | pit_irq;             // RULE_06
    assign exit_any   = (held_mode_r == `LPC_MODE_SLEEP) ? exit_sleep : exit_light;
    assign low_sel    = power_mode_select_r != `LPC_MODE_NORMAL;
    assign clk_rst    = ~ext_reset_n | (osc_lost & loo_re_r) | (pll_unlocked & lol_re_r); // RULE_23
    // Clock reset is registered so the clock state can be cleared cleanly.
    always_ff @(posedge clock or posedge rst)
        if (rst)
            clock_reset_r <= 1'b1;
        else
            clock_reset_r <= clk_rst;
    // AXI write channel: address and data taken in either order.
    assign wr_fire = aw_hold_r & w_hold_r & ~s_axi_bvalid;
    assign wr_ok   = (aw_addr_r >= `LPC_ADDR_CTRL) && (aw_addr_r <= `LPC_ADDR_STAT); // Aligned, so the span is exact.
    always_ff @(posedge clock or posedge rst)
        if (rst)
        begin
            aw_hold_r     <= 1'b0;
            w_hold_r      <= 1'b0;
            aw_addr_r     <= 12'h000;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `LPC_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= ~aw_hold_r & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready  <= ~w_hold_r & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid & s_axi_awready)
            begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[11:2], 2'h0};
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `LPC_RESP_OKAY : `LPC_RESP_SLVERR;
            end
            else if (s_axi_bvalid & s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
            end
        end
    // Control fields; clock reset (also high through rst) restores defaults.
    always_ff @(posedge clock)
        if (clock_reset_r)
        begin
            irq_wake_mask_r  <= 1'b0;
            dec_en_r         <= 1'b1;                                 // RULE_22
            lol_re_r         <= 1'b0;
            loo_re_r         <= 1'b0;
            pll_multiplier_r <= `LPC_MF_RESET;
            output_divider_r <= `LPC_DIV_RESET;
            power_mode_select_r <= `LPC_MODE_NORMAL;                  // RULE_03
        end
        else
        begin
            if (wr_fire && aw_addr_r == `LPC_ADDR_CTRL)
            begin
                if (w_strb_r[3])
                begin
                    irq_wake_mask_r <= w_data_r[`LPC_BIT_WAKE_MASK];  // RULE_12
                    dec_en_r <= w_data_r[`LPC_BIT_DEC_EN];
                    lol_re_r <= w_data_r[`LPC_BIT_LOL_RE];
                    loo_re_r <= w_data_r[`LPC_BIT_LOO_RE];
                end
                if (w_strb_r[2] && !mul_lock_r)                       // RULE_13
                    pll_multiplier_r <= w_data_r[`LPC_MF_HI:`LPC_MF_LO];
                if (w_strb_r[0] && !div_lock_r)                       // RULE_13
                    output_divider_r <= w_data_r[`LPC_DIV_HI:`LPC_DIV_LO];
                if (w_strb_r[1] && !mode_lock_r)                      // RULE_13
                    power_mode_select_r <= w_data_r[`LPC_MODE_HI:`LPC_MODE_LO];
            end
            // Exit wins over a same-cycle write; an unmasked irq clears even in normal mode.
            if ((state_r == LPC_WAKE) || irq_wake)                    // RULE_11
                power_mode_select_r <= `LPC_MODE_NORMAL;              // RULE_03
        end
    // Lock bits: sticky once set unless freeze is active.
    always_ff @(posedge clock)
        if (clock_reset_r)
        begin
            mul_lock_r  <= 1'b0;
            mode_lock_r <= 1'b0;
            div_lock_r  <= 1'b0;
        end
        else if (wr_fire && aw_addr_r == `LPC_ADDR_LOCK && w_strb_r[3])
        begin
            mul_lock_r  <= freeze ? w_data_r[`LPC_BIT_MUL_LOCK]  : (mul_lock_r  | w_data_r[`LPC_BIT_MUL_LOCK]);  // RULE_14
            mode_lock_r <= freeze ? w_data_r[`LPC_BIT_MODE_LOCK] : (mode_lock_r | w_data_r[`LPC_BIT_MODE_LOCK]); // RULE_14
            div_lock_r  <= freeze ? w_data_r[`LPC_BIT_DIV_LOCK]  : (div_lock_r  | w_data_r[`LPC_BIT_DIV_LOCK]);  // RULE_14
        end
    // Freeze clock-stop enable; resets to zero.
    always_ff @(posedge clock or posedge rst)
        if (rst)
            frz_stop_r <= 1'b0;
        else if (wr_fire && aw_addr_r == `LPC_ADDR_MCR && w_strb_r[0])
            frz_stop_r <= w_data_r[`LPC_BIT_FRZ_STOP];
    // Wake request: no reset on purpose, it lives on keep-alive power; hardware set wins.
    always_ff @(posedge clock)
        if (dec_en_live_r && tick_r && !dec_r[31] && dec_r == 32'h0000_0000)
            wake_request_bit_r <= 1'b1;                               // RULE_16
        else if (wr_fire && aw_addr_r == `LPC_ADDR_LOCK && w_strb_r[1])
            wake_request_bit_r <= w_data_r[`LPC_BIT_WAKE_REQ];        // RULE_15
    always_ff @(posedge clock)
        power_up_request_pin <= wake_request_bit_r;                   // RULE_15
    // Crystal divide by four; tick gated by sleep and by freeze at the falling edge.
    always_ff @(posedge clock or posedge rst)
        if (rst)
        begin
            xtal_q_r <= 1'b0;
            xdiv_r   <= 2'h0;
            tick_r   <= 1'b0;
        end
        else
        begin
            xtal_q_r <= xtal_clk;
            tick_r   <= 1'b0;
            if (xtal_clk && !xtal_q_r && gates_r.timer_clk_en)        // RULE_20
            begin
                xdiv_r <= xdiv_r + 2'h1;
                tick_r <= (xdiv_r == `LPC_XTAL_DIV) && frz_n_r;       // RULE_20
            end
        end
    always_ff @(negedge clock or posedge rst)
        if (rst)
            frz_n_r <= 1'b1;
        else
            frz_n_r <= ~(freeze & frz_stop_r);                        // RULE_21
    // Time base and decrementer: untouched by any reset.
    always_ff @(posedge clock)
        if (wr_fire && aw_addr_r == `LPC_ADDR_TB_LO)
            timebase_r[31:0] <= w_data_r;                             // RULE_17
        else if (wr_fire && aw_addr_r == `LPC_ADDR_TB_HI)
            timebase_r[63:32] <= w_data_r;
        else if (tick_r)
            timebase_r <= {timebase_r[63:32] + 32'(&timebase_r[31:0]), timebase_r[31:0] + 32'h1}; // RULE_17
    always_ff @(posedge clock)
        if (wr_fire && aw_addr_r == `LPC_ADDR_DEC)
            dec_r <= w_data_r;
        else if (tick_r && dec_en_live_r)
            dec_r <= dec_r - 32'h1;                                   // RULE_19
    always_ff @(posedge clock)
        if (tick_r)
            dec_en_live_r <= dec_en_r;                                // RULE_22
    // Decrementer interrupt on passing zero, masked by the core enable.
    always_ff @(posedge clock or posedge rst)
        if (rst)
            dec_irq_r <= 1'b0;
        else
            dec_irq_r <= tick_r && dec_en_live_r && dec_r == 32'h0000_0000 && interrupt_enable_bit; // RULE_18
    // Exit latch: registered on the rising clock edge, so a sleep wake needs a running clock edge first.
    always_ff @(posedge clock or posedge rst)
        if (rst)
            exit_async_r <= 1'b0;
        else
            exit_async_r <= exit_any && state_r == LPC_LOW;           // RULE_08
    // Mode sequencer and clock gates.
    always_ff @(posedge clock or posedge rst)
        if (rst)
        begin
            state_r     <= LPC_RUN;
            held_mode_r <= `LPC_MODE_NORMAL;
            exit_cnt_r  <= 8'h00;
            bus_block_r <= 1'b0;
            gates_r     <= '{1'b1, 1'b1, 1'b1, 1'b1};
        end
        else
        begin
            unique case (state_r)
                LPC_RUN:
                    if (low_sel && !irq_wake)
                    begin
                        bus_block_r <= 1'b1;                          // RULE_01
                        held_mode_r <= power_mode_select_r;
                        state_r     <= LPC_DRAIN;
                    end
                LPC_DRAIN:
                    if (!bus_cycle_busy)                              // RULE_01
                    begin
                        gates_r.sysclk_out_en <= 1'b0;                // RULE_04
                        gates_r.core_clk_en   <= held_mode_r == `LPC_MODE_SINGLE; // RULE_05
                        gates_r.osc_pll_en    <= held_mode_r != `LPC_MODE_SLEEP || debug_mode; // RULE_02
                        gates_r.timer_clk_en  <= held_mode_r != `LPC_MODE_SLEEP;  // RULE_20
                        state_r               <= LPC_LOW;
                    end
                LPC_LOW:
                begin
                    gates_r.osc_pll_en <= held_mode_r != `LPC_MODE_SLEEP || debug_mode; // RULE_02
                    if (exit_async_r)
                    begin
                        exit_cnt_r <= (held_mode_r == `LPC_MODE_SLEEP) ? SLEEP_CYC : 8'(`LPC_EXIT_CYCLES - 1); // RULE_10
                        gates_r.osc_pll_en <= 1'b1;
                        state_r    <= LPC_WAKE;
                    end
                end
                LPC_WAKE:
                    if (exit_cnt_r <= 8'h01)
                    begin
                        gates_r     <= '{1'b1, 1'b1, 1'b1, 1'b1};    // RULE_10
                        bus_block_r <= 1'b0;
                        held_mode_r <= `LPC_MODE_NORMAL;
                        state_r     <= LPC_RUN;
                    end
                    else
                        exit_cnt_r <= exit_cnt_r - 8'h01;
            endcase
        end
    // Read channel: one read at a time, answer one cycle after address.
    assign ctrl_word = {3'h0, irq_wake_mask_r, 1'b0, dec_en_r, lol_re_r, loo_re_r, 1'b0,
                        pll_multiplier_r, 9'h000, power_mode_select_r, 4'h0, output_divider_r};
    assign lock_word = {5'h00, mul_lock_r, mode_lock_r, div_lock_r, 15'h0000,
                        wake_request_bit_r, 8'h00};
    always_comb
    begin
        unique case ({s_axi_araddr[11:2], 2'h0})
            `LPC_ADDR_CTRL:  rd_word = ctrl_word;
            `LPC_ADDR_LOCK:  rd_word = lock_word;
            `LPC_ADDR_TB_LO: rd_word = timebase_r[31:0];
            `LPC_ADDR_TB_HI: rd_word = timebase_r[63:32];
            `LPC_ADDR_DEC:   rd_word = dec_r;
            `LPC_ADDR_MCR:   rd_word = {31'h0, frz_stop_r};
            `LPC_ADDR_STAT:  rd_word = {24'h0, state_r, gates_r};
            default:         rd_word = 32'h0000_0000;
        endcase
    end
    assign rd_fire = s_axi_arvalid & s_axi_arready;
    always_ff @(posedge clock or posedge rst)
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `LPC_RESP_OKAY;
            ar_busy_r     <= 1'b0;
        end
        else
        begin
            s_axi_arready <= ~ar_busy_r & ~rd_fire;
            if (rd_fire)
            begin
                ar_busy_r    <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= (s_axi_araddr >= `LPC_ADDR_CTRL && s_axi_araddr < `LPC_ADDR_STAT + 12'h4) ?
                                `LPC_RESP_OKAY : `LPC_RESP_SLVERR;
            end
            else if (s_axi_rvalid & s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                ar_busy_r    <= 1'b0;
            end
        end
    // Checks on the sequencer and registers.
    sequence s_drain_done;
        state_r == LPC_DRAIN && !bus_cycle_busy;
    endsequence
    property p_gate_after_drain;
        @(posedge clock) disable iff (rst) s_drain_done |=> !gates_r.sysclk_out_en && bus_block_r;
    endproperty
    a_gate_after_drain: assert property (p_gate_after_drain) else $error("clocks not gated after drain"); // RULE_01
    property p_hold_while_busy;
        @(posedge clock) disable iff (rst) state_r == LPC_DRAIN && bus_cycle_busy |=> gates_r.core_clk_en;
    endproperty
    a_hold_while_busy: assert property (p_hold_while_busy) else $error("clock stopped during bus cycle"); // RULE_01
    property p_debug_osc;
        @(posedge clock) disable iff (rst) debug_mode && state_r == LPC_LOW ##1 debug_mode |-> gates_r.osc_pll_en;
    endproperty
    a_debug_osc: assert property (p_debug_osc) else $error("oscillator off in debug"); // RULE_02
    property p_irq_clears_mode;
        @(posedge clock) disable iff (rst || clock_reset_r) irq_wake |=> power_mode_select_r == `LPC_MODE_NORMAL;
    endproperty
    a_irq_clears_mode: assert property (p_irq_clears_mode) else $error("irq did not clear mode"); // RULE_11
    property p_mode_lock;
        @(posedge clock) disable iff (rst || clock_reset_r)
            mode_lock_r && !irq_wake && state_r != LPC_WAKE |=> $stable(power_mode_select_r);
    endproperty
    a_mode_lock: assert property (p_mode_lock) else $error("locked mode changed"); // RULE_13
    property p_lock_sticky;
        @(posedge clock) disable iff (rst || clock_reset_r || freeze) mul_lock_r |=> mul_lock_r;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared outside freeze"); // RULE_14
    property p_pin_follows;
        @(posedge clock) disable iff (rst) ##1 power_up_request_pin === $past(wake_request_bit_r);
    endproperty
    a_pin_follows: assert property (p_pin_follows) else $error("pin not driven by wake bit"); // RULE_15
    property p_light_exit_time;
        @(posedge clock) disable iff (rst)
            state_r == LPC_LOW && exit_async_r && held_mode_r != `LPC_MODE_SLEEP |-> ##2 state_r == LPC_RUN;
    endproperty
    a_light_exit_time: assert property (p_light_exit_time) else $error("light mode exit delay wrong"); // RULE_10
    property p_sleep_timers;
        @(posedge clock) disable iff (rst)
            held_mode_r == `LPC_MODE_SLEEP && state_r == LPC_LOW && $past(state_r) == LPC_LOW |-> !tick_r;
    endproperty
    a_sleep_timers: assert property (p_sleep_timers) else $error("counter ticked in sleep"); // RULE_20
endmodule // lpc_ctrl

// ==== shared/lpc_consts.svh ====
// Constants for the low-power mode and time base controller.
// Assumes inclusion by the package, the core module and the testbench.
`ifndef LPC_CONSTS_SVH
`define LPC_CONSTS_SVH
`define LPC_ADDR_CTRL      12'h050
`define LPC_ADDR_LOCK      12'h054
`define LPC_ADDR_TB_LO     12'h058
`define LPC_ADDR_TB_HI     12'h05C
`define LPC_ADDR_DEC       12'h060
`define LPC_ADDR_MCR       12'h064
`define LPC_ADDR_STAT      12'h068
`define LPC_MODE_NORMAL    2'h0
`define LPC_MODE_SINGLE    2'h1
`define LPC_MODE_DOZE      2'h2
`define LPC_MODE_SLEEP     2'h3
`define LPC_MF_RESET       4'h2
`define LPC_DIV_RESET      4'h3
`define LPC_BIT_WAKE_MASK  28
`define LPC_BIT_DEC_EN     26
`define LPC_BIT_LOL_RE     25
`define LPC_BIT_LOO_RE     24
`define LPC_MF_HI          22
`define LPC_MF_LO          19
`define LPC_MODE_HI        9
`define LPC_MODE_LO        8
`define LPC_DIV_HI         3
`define LPC_DIV_LO         0
`define LPC_BIT_MUL_LOCK   26
`define LPC_BIT_MODE_LOCK  25
`define LPC_BIT_DIV_LOCK   24
`define LPC_BIT_WAKE_REQ   8
`define LPC_BIT_FRZ_STOP   0
`define LPC_XTAL_DIV       2'h3
`define LPC_EXIT_CYCLES    2'h2
`define LPC_SLEEP_WAKE_NS  1000
`define LPC_CLK_NS         10
`define LPC_RESP_OKAY      2'h0
`define LPC_RESP_SLVERR    2'h2
`endif

// ==== shared/lpc_pkg.sv ====
// Types for the low-power mode and time base controller.
// Assumes the constants header is on the include path.
`include "lpc_consts.svh"
package lpc_pkg;
    typedef enum logic [3:0] {
        LPC_RUN   = 4'h1,
        LPC_DRAIN = 4'h2,
        LPC_LOW   = 4'h4,
        LPC_WAKE  = 4'h8
    } lpc_state_t;
    // Clock gates driven toward the clock tree.
    typedef struct packed {
        logic sysclk_out_en;
        logic core_clk_en;
        logic osc_pll_en;
        logic timer_clk_en;
    } lpc_gates_t;
endpackage

// ==== testbench/lpc_far_model.sv ====
// Far side: bus interface cycles and the crystal.
// Assumes the block's clock; crystal at a quarter of it.
module lpc_far_model
    import lpc_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic start,
    input  wire logic bus_block_r,
    output logic      bus_cycle_busy,
    output logic      xtal_clk
);
    logic [3:0] left_r;
    logic [1:0] ph_r;
    // A twelve-clock cycle starts only while new cycles are not blocked.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst) left_r <= 4'h0;
        else if (left_r != 4'h0) left_r <= left_r - 4'h1;
        else if (start && !bus_block_r) left_r <= 4'hC;
    end
    // Free-running crystal; sleep is judged by the gates.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst) ph_r <= 2'h0;
        else ph_r <= ph_r + 2'h1;
    end
    assign bus_cycle_busy = (left_r != 4'h0);
    assign xtal_clk       = ph_r[1];
endmodule // lpc_far_model

// ==== testbench/testbench.sv ====
// Bench: registers, gating, wake and counters.
// Assumes the far-side model and the constants header on the include path.
`include "lpc_consts.svh"
module testbench
    import lpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, rst, start, bus_block_r, power_up_request_pin, dec_irq_r, clock_reset_r, xtal_clk, pit_irq;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, ext_reset_n, freeze, debug_mode, bus_cycle_busy;
    logic interrupt_enable_bit, osc_lost, pll_unlocked;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, irq_n, rd_r;
    lpc_gates_t  gates_r;
    int          fail_count = 0, n_compared = 0, cyc = 0, irqs = 0;
    lpc_ctrl #(.SLEEP_WAKE_CYC(4)) u_lpc_ctrl (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ext_reset_n, .irq_n, .osc_lost, .pll_unlocked, .xtal_clk, .debug_mode, .freeze,
        .interrupt_enable_bit, .pit_irq, .bus_cycle_busy, .bus_block_r, .gates_r, .power_up_request_pin,
        .dec_irq_r, .clock_reset_r);
    lpc_far_model u_lpc_far_model (.clock, .rst, .start, .bus_block_r, .bus_cycle_busy, .xtal_clk);
    // The 100 MHz clock.
    initial
    begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end
    // Hang ceiling; counts decrementer interrupt pulses.
    always @(posedge clock)
    begin
        cyc++;
        if (dec_irq_r === 1'h1) irqs++;
        if (cyc == 6000) begin fail_count++; end_sim(); end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin fail_count++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wt(input int n); repeat (n) @(posedge clock); endtask
    task automatic wn(input int n); repeat (n) @(negedge clock); endtask
    // One bus access; outputs are sampled at the falling edge, where they are settled.
    task automatic acc(input logic wr, input logic [11:0] ad, input logic [31:0] d, input logic [31:0] m);
        logic aw, w, ar, dn;
        @(posedge clock);
        if (wr) begin s_axi_awaddr <= ad; s_axi_wdata <= d; s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1; end
        else begin s_axi_araddr <= ad; s_axi_arvalid <= 1'h1; end
        s_axi_bready <= wr;
        s_axi_rready <= !wr;
        dn = 1'h0;
        while (!dn)
        begin
            @(negedge clock);
            aw = s_axi_awready && s_axi_awvalid; w = s_axi_wready && s_axi_wvalid;
            ar = s_axi_arready && s_axi_arvalid; dn = wr ? s_axi_bvalid : s_axi_rvalid;
            rd_v = s_axi_rdata; rd_r = s_axi_rresp;
            @(posedge clock);
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
            if (ar) s_axi_arvalid <= 1'h0;
            if (dn) begin s_axi_bready <= 1'h0; s_axi_rready <= 1'h0; end
        end
        if (!wr) chk(rd_v & m, d);
    endtask
    // Bounded wait for the gates, then compare.
    task automatic wg(input logic [3:0] e);
        for (int i = 0; i < 60 && gates_r !== e; i++) @(negedge clock);
        chk(32'(gates_r), 32'(e));
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] d); acc(1'h1, ad, d, 32'h0); endtask
    task automatic t_regs();
        acc(1'h0, `LPC_ADDR_CTRL, 32'h0410_0003, 32'hFFFF_FFFF);
        acc(1'h0, `LPC_ADDR_LOCK, 32'h0, 32'h0700_0000);
        acc(1'h0, 12'h0FC, 32'h0, 32'hFFFF_FFFF);
        chk(32'(rd_r), 32'(`LPC_RESP_SLVERR));
        wr(`LPC_ADDR_LOCK, 32'h0200_0000);
        wr(`LPC_ADDR_CTRL, 32'h1410_0103);
        acc(1'h0, `LPC_ADDR_CTRL, 32'h1410_0003, 32'hFFFF_FFFF);
        wr(`LPC_ADDR_LOCK, 32'h0);
        acc(1'h0, `LPC_ADDR_LOCK, 32'h0200_0000, 32'h0700_0000);
        freeze <= 1'h1;
        wr(`LPC_ADDR_LOCK, 32'h0);
        acc(1'h0, `LPC_ADDR_LOCK, 32'h0, 32'h0700_0000);
        freeze <= 1'h0;
        $display("registers and locks done");
    endtask
    // Reads ~66 clocks apart: four or five ticks.
    task automatic t_count();
        logic [31:0] b;
        wr(`LPC_ADDR_TB_LO, 32'h0);
        acc(1'h0, `LPC_ADDR_TB_LO, 32'h0, 32'h0);
        b = rd_v;
        wt(62);
        acc(1'h0, `LPC_ADDR_TB_LO, 32'h0, 32'h0);
        chk((rd_v - b) >> 1, 32'h2);
        wr(`LPC_ADDR_DEC, 32'h100);
        for (int en = 1; en >= 0; en--)
        begin
            wr(`LPC_ADDR_LOCK, 32'h100);
            interrupt_enable_bit <= 1'(en);
            wn(2);
            chk(32'(power_up_request_pin), 32'h1);
            wr(`LPC_ADDR_LOCK, 32'h0);
            wn(2);
            chk(32'(power_up_request_pin), 32'h0);
            irqs = 0;
            wr(`LPC_ADDR_DEC, 32'h1);
            wn(80);
            chk(32'(power_up_request_pin), 32'h1);
            chk(32'(irqs), 32'(en));
        end
        $display("counters and wake done");
    endtask
    task automatic t_modes();
        wr(`LPC_ADDR_CTRL, 32'h0410_0103);
        wg(4'h7);
        wt(1);
        irq_n <= 2'h2;
        wt(6);
        irq_n <= 2'h3;
        wg(4'h7);
        wr(`LPC_ADDR_CTRL, 32'h1410_0103);
        irq_n <= 2'h1;
        wt(2);
        irq_n <= 2'h3;
        wg(4'hF);
        acc(1'h0, `LPC_ADDR_CTRL, 32'h0, 32'h300);
        start <= 1'h1;
        wt(1);
        start <= 1'h0;
        wr(`LPC_ADDR_CTRL, 32'h1410_0203);
        wn(1);
        chk(32'({bus_block_r, gates_r}), 32'h1F);
        wg(4'h3);
        wt(1);
        pit_irq <= 1'h1;
        wt(2);
        pit_irq <= 1'h0;
        wg(4'hF);
        acc(1'h0, `LPC_ADDR_CTRL, 32'h0, 32'h300);
        for (int dbg = 0; dbg < 2; dbg++)
        begin
            wt(1);
            debug_mode <= 1'(dbg);
            wr(`LPC_ADDR_CTRL, 32'h1410_0303);
            wt(4);
            pit_irq <= 1'h1;
            wt(2);
            pit_irq <= 1'h0;
            wn(8);
            chk(32'(gates_r[3:1]), 32'(dbg));
            wt(1);
            irq_n <= 2'h1;
            wt(2);
            irq_n <= 2'h3;
            wg(4'hF);
        end
        $display("low-power modes done");
    endtask
    // Inputs defined at time zero; reset for four cycles.
    initial
    begin
        rst = 1'h1; start = 1'h0; s_axi_awvalid = 1'h0; s_axi_wvalid = 1'h0; s_axi_bready = 1'h0;
        s_axi_arvalid = 1'h0; s_axi_rready = 1'h0; s_axi_awaddr = 12'h0; s_axi_araddr = 12'h0; s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF; ext_reset_n = 1'h1; irq_n = 2'h3; osc_lost = 1'h0; pll_unlocked = 1'h0;
        debug_mode = 1'h0; freeze = 1'h0; interrupt_enable_bit = 1'h0; pit_irq = 1'h0;
        wt(4);
        rst <= 1'h0;
        wt(2);
        t_regs();
        t_count();
        t_modes();
        end_sim();
    end
endmodule // testbench
